// file: rtl/cln_defs.svh
// Constants for the copper link negotiation and crossover controller
`ifndef CLN_DEFS_SVH
`define CLN_DEFS_SVH

`define CLN_CLK_HZ       32'h017D_7840
`define CLN_DOWN_SEC     32'h0000_0004
`define CLN_DOWN_CYC     (`CLN_DOWN_SEC * `CLN_CLK_HZ)
`define CLN_SLOT_MS      32'h0000_003E
`define CLN_MS_PER_S     32'h0000_03E8
`define CLN_SLOT_CYC     (`CLN_SLOT_MS * `CLN_CLK_HZ / `CLN_MS_PER_S)

`define CLN_OFF_CTRL     8'h00
`define CLN_OFF_ADV      8'h04
`define CLN_OFF_STAT     8'h08

`define CLN_CTRL_AN      0
`define CLN_CTRL_SPD100  1
`define CLN_CTRL_FULL    2
`define CLN_CTRL_MDIX    3
`define CLN_CTRL_RST     4'h9

`define CLN_AB_10HD      0
`define CLN_AB_10FD      1
`define CLN_AB_100HD     2
`define CLN_AB_100FD     3
`define CLN_ADV_RST      4'hF

`define CLN_LFSR_SEED    8'h01
`define CLN_SYNC_W       9

`endif

// file: rtl/cln_pkg.sv
// Types shared by the link negotiation controller
package cln_pkg;
    typedef enum logic [4:0] {
        S_AN_WAIT   = 5'h01,
        S_AN_UP     = 5'h02,
        S_FORCED    = 5'h04,
        S_FORCED_UP = 5'h08,
        S_TEMP_AN   = 5'h10
    } cln_state_t;
endpackage : cln_pkg

// file: rtl/cln_sat_timer.sv
// Saturating interval counter with synchronous clear
module cln_sat_timer #(
    parameter int LIMIT = 1
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic clear,
    output logic      done
);
    localparam int W = $clog2(LIMIT + 1);

    if (LIMIT < 1) begin : g_bad_limit
        $error("cln_sat_timer: LIMIT must be at least one");
    end

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign done = (cnt_reg == W'(LIMIT));

    always_comb begin
        if (clear) begin
            cnt_next = '0;
        end else if (done) begin
            cnt_next = cnt_reg;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_clear_zeroes: assert property (clear |=> cnt_reg == '0)
        else $error("Timer not cleared");
    a_saturate_hold: assert property (
        done && !clear |=> done && $stable(cnt_reg))
        else $error("Timer left saturation");
endmodule : cln_sat_timer

// file: rtl/cln_link_ctrl.sv
// Copper link negotiation, crossover and forced-mode fallback with AHB regs
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`include "cln_defs.svh"

// Functional notes
// - Each of the four advertised abilities is a separate writable bit.
// - Negotiation picks the best speed and duplex both ends advertise.
// - Negotiation starts unswapped: transmit on transmit pair.
// - Pairs swap when needed so transmitter reaches partner receiver.
// - Random swap timing leaves exactly one crossover-capable end swapped.
// - Pair swaps are corrected internally at 100 Mb/s without software.
// - Negotiation may be off with forced speed; crossover stays available.
// - Forced link down four seconds enables temporary negotiation (only with crossover enabled).
// - Link pulses or idles during temporary negotiation restore forced mode.
module cln_link_ctrl
    import cln_pkg::*;
#(
    parameter int DOWN_CYCLES = `CLN_DOWN_CYC,
    parameter int SLOT_CYCLES = `CLN_SLOT_CYC
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic [3:0]         lp_abil_pin,
    input  wire logic               lp_page_pin,
    input  wire logic               link_ok_pin,
    input  wire logic               rx_energy_pin,
    input  wire logic               link_pulse_pin,
    input  wire logic               idle100_pin,
    output logic                    mdix_sel,
    output logic                    an_active,
    output logic                    phy_speed100,
    output logic                    phy_full,
    output logic                    st_link,
    output logic                    st_speed100,
    output logic                    st_full,
    output logic                    st_mdix,
    output cln_pkg::cln_state_t     fsm_state
);
    import cln_pkg::*;

    // Pin synchroniser; ability bits are qualified by the page flag
    logic [`CLN_SYNC_W-1:0] sync1_reg;
    logic [`CLN_SYNC_W-1:0] sync2_reg;
    logic [3:0]             lp_abil_s;
    logic                   lp_page_s;
    logic                   link_ok_s;
    logic                   rx_energy_s;
    logic                   link_pulse_s;
    logic                   idle100_s;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {lp_abil_pin, lp_page_pin, link_ok_pin,
                          rx_energy_pin, link_pulse_pin, idle100_pin};
            sync2_reg <= sync1_reg;
        end
    end
    assign {lp_abil_s, lp_page_s, link_ok_s,
            rx_energy_s, link_pulse_s, idle100_s} = sync2_reg;

    // Bus slave: zero wait states, read data captured in address phase
    logic        dp_wr_reg;
    logic        dp_wr_next;
    logic [7:0]  dp_addr_reg;
    logic [7:0]  dp_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic [3:0]  ctrl_reg;
    logic [3:0]  ctrl_next;
    logic [3:0]  adv_reg;
    logic [3:0]  adv_next;
    logic        ap_valid;
    logic [31:0] rd_word;

    assign ap_valid  = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_comb begin
        case (haddr[7:0])
            `CLN_OFF_CTRL: rd_word = {28'h000_0000, ctrl_reg};
            `CLN_OFF_ADV:  rd_word = {28'h000_0000, adv_reg};
            `CLN_OFF_STAT: rd_word = {22'h00_0000, an_active, fsm_state,
                                      st_mdix, st_full, st_speed100, st_link};
            default:       rd_word = 32'h0000_0000;
        endcase
        dp_wr_next   = ap_valid && hwrite;
        dp_addr_next = ap_valid ? haddr[7:0] : dp_addr_reg;
        hrdata_next  = (ap_valid && !hwrite) ? rd_word : hrdata_reg;
        ctrl_next    = ctrl_reg;
        adv_next     = adv_reg;
        if (dp_wr_reg && dp_addr_reg == `CLN_OFF_CTRL) begin
            ctrl_next = hwdata[3:0];
        end
        if (dp_wr_reg && dp_addr_reg == `CLN_OFF_ADV) begin
            adv_next = hwdata[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
            ctrl_reg    <= `CLN_CTRL_RST;
            adv_reg     <= `CLN_ADV_RST;
        end else begin
            dp_wr_reg   <= dp_wr_next;
            dp_addr_reg <= dp_addr_next;
            hrdata_reg  <= hrdata_next;
            ctrl_reg    <= ctrl_next;
            adv_reg     <= adv_next;
        end
    end

    logic an_en;
    logic cfg_spd100;
    logic cfg_full;
    logic mdix_en;
    assign an_en      = ctrl_reg[`CLN_CTRL_AN];
    assign cfg_spd100 = ctrl_reg[`CLN_CTRL_SPD100];
    assign cfg_full   = ctrl_reg[`CLN_CTRL_FULL];
    assign mdix_en    = ctrl_reg[`CLN_CTRL_MDIX];

    // Highest shared mode: {found, speed100, full}
    function automatic logic [2:0] pick_mode(input logic [3:0] c);
        if (c[`CLN_AB_100FD]) begin
            pick_mode = 3'h7;
        end else if (c[`CLN_AB_100HD]) begin
            pick_mode = 3'h6;
        end else if (c[`CLN_AB_10FD]) begin
            pick_mode = 3'h5;
        end else if (c[`CLN_AB_10HD]) begin
            pick_mode = 3'h4;
        end else begin
            pick_mode = 3'h0;
        end
    endfunction : pick_mode

    logic [2:0] highest_shared_mode;
    assign highest_shared_mode = pick_mode(adv_reg & lp_abil_s);

    // Down interval and crossover slot timers
    logic down_done;
    logic slot_done;
    logic hunting;
    cln_sat_timer #(.LIMIT(DOWN_CYCLES)) u_down (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clear   (fsm_state != S_FORCED || link_ok_s),
        .done    (down_done)
    );
    cln_sat_timer #(.LIMIT(SLOT_CYCLES)) u_slot (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clear   (slot_done || !hunting),
        .done    (slot_done)
    );

    // Link state and held status
    cln_state_t state_reg;
    cln_state_t state_next;
    logic [3:0] stat_reg;
    logic [3:0] stat_next;
    logic [1:0] phy_reg;
    logic [1:0] phy_next;
    logic       mdix_reg;
    logic       mdix_next;
    logic [7:0] lfsr_reg;
    logic [7:0] lfsr_next;

    always_comb begin
        state_next = state_reg;
        stat_next  = stat_reg;
        phy_next   = phy_reg;
        case (state_reg)
            S_AN_WAIT: begin
                phy_next = 2'h0;
                if (!an_en) begin
                    state_next = S_FORCED;
                end else if (lp_page_s && link_ok_s
                             && highest_shared_mode[2]) begin
                    state_next = S_AN_UP;
                    phy_next   = highest_shared_mode[1:0];
                    stat_next  = {mdix_reg, highest_shared_mode[0],
                                  highest_shared_mode[1], 1'b1};
                end
            end
            S_AN_UP, S_FORCED_UP: begin
                if (an_en != (state_reg == S_AN_UP) || !link_ok_s) begin
                    state_next = an_en ? S_AN_WAIT : S_FORCED;
                    stat_next  = 4'h0;
                end
            end
            S_FORCED: begin
                phy_next = {cfg_spd100, cfg_full};
                if (an_en) begin
                    state_next = S_AN_WAIT;
                end else if (link_ok_s) begin
                    state_next = S_FORCED_UP;
                    stat_next  = {mdix_reg, cfg_full,
                                  cfg_spd100, 1'b1};
                end else if (down_done && mdix_en) begin
                    state_next = S_TEMP_AN;
                end
            end
            S_TEMP_AN: begin
                if (an_en) begin
                    state_next = S_AN_WAIT;
                end else if (link_pulse_s || idle100_s) begin
                    state_next = S_FORCED;
                end
            end
            default: begin
                state_next = S_AN_WAIT;
                stat_next  = 4'h0;
            end
        endcase
    end

    // Crossover hunt: random slot decisions break symmetry with a like end
    assign hunting = mdix_en && !rx_energy_s
                     && (state_reg inside {S_AN_WAIT, S_FORCED, S_TEMP_AN});

    always_comb begin
        lfsr_next = {lfsr_reg[6:0],
                     lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        mdix_next = mdix_reg;
        if (!mdix_en) begin
            mdix_next = 1'b0;
        end else if (hunting && slot_done && lfsr_reg[0]) begin
            mdix_next = !mdix_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_reg <= S_AN_WAIT;
            stat_reg  <= 4'h0;
            phy_reg   <= 2'h0;
            mdix_reg  <= 1'b0;
            lfsr_reg  <= `CLN_LFSR_SEED;
        end else begin
            state_reg <= state_next;
            stat_reg  <= stat_next;
            phy_reg   <= phy_next;
            mdix_reg  <= mdix_next;
            lfsr_reg  <= lfsr_next;
        end
    end

    assign fsm_state = state_reg;
    assign mdix_sel  = mdix_reg;
    assign an_active = (state_reg inside {S_AN_WAIT, S_AN_UP, S_TEMP_AN});
    assign {phy_speed100, phy_full} = phy_reg;
    assign {st_mdix, st_full, st_speed100, st_link} = stat_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_forced_long_down;
        state_reg == S_FORCED && !link_ok_s && !an_en && mdix_en && down_done;
    endsequence
    sequence s_activity_seen;
        state_reg == S_TEMP_AN && !an_en && (link_pulse_s || idle100_s);
    endsequence

    a_adv_write: assert property (
        ap_valid && hwrite && haddr[7:0] == `CLN_OFF_ADV
        ##1 1'b1 |=> adv_reg == $past(hwdata[3:0]))
        else $error("Ability write not applied");
    a_hcd_full100: assert property (state_reg == S_AN_WAIT && an_en && lp_page_s
        && link_ok_s && adv_reg[`CLN_AB_100FD] && lp_abil_s[`CLN_AB_100FD]
        |=> st_link && st_speed100 && st_full)
        else $error("Best shared mode not chosen");
    a_start_unswapped: assert property ($past(!resetn) |-> !mdix_sel)
        else $error("Crossover not clear after reset");
    a_hunt_toggle: assert property (hunting && slot_done && lfsr_reg[0]
        |=> mdix_sel != $past(mdix_sel))
        else $error("Crossover did not toggle");
    a_energy_holds: assert property (rx_energy_s |=> $stable(mdix_sel))
        else $error("Swap moved while signal present");
    a_up_swap_stable: assert property (st_link && $past(st_link)
        |-> $stable(mdix_sel) && st_mdix == mdix_sel)
        else $error("Swap changed during link");
    a_forced_speed: assert property (
        state_reg == S_FORCED ##1 state_reg == S_FORCED
        |-> phy_speed100 == $past(cfg_spd100))
        else $error("Forced speed not applied");
    a_temp_an_entry: assert property (
        s_forced_long_down |=> state_reg == S_TEMP_AN)
        else $error("Temporary negotiation not entered");
    a_temp_an_exit: assert property (s_activity_seen |=> state_reg == S_FORCED
        ##1 !an_active)
        else $error("Forced mode not restored");
    a_status_hold: assert property (st_link && link_ok_s
        && an_en == (state_reg == S_AN_UP)
        |=> st_link && $stable({st_speed100, st_full, st_mdix}))
        else $error("Status changed while link up");
endmodule : cln_link_ctrl

// file: testbench/cln_partner.sv
// Remote transceiver model at the far end of the cable
module cln_partner (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       mdix_sel,
    input  wire logic       present,
    input  wire logic       cable_cross,
    input  wire logic       mode100,
    input  wire logic [3:0] abil,
    output logic      [3:0] lp_abil_pin,
    output logic            lp_page_pin,
    output logic            link_ok_pin,
    output logic            rx_energy_pin,
    output logic            link_pulse_pin,
    output logic            idle100_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] up_cnt;
    logic       aligned;
    // No crossover of its own: only the device swap or a crossed cable can align pairs
    assign aligned = present & (mdix_sel ^ cable_cross);
    always @(posedge ref_clk) begin
        if (!resetn || !aligned) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    assign rx_energy_pin  = aligned;
    assign link_ok_pin    = (up_cnt == 3'h7);
    assign lp_page_pin    = link_ok_pin;
    // No page held: show the inverse, not stale abilities
    assign lp_abil_pin    = lp_page_pin ? abil : ~abil;
    assign link_pulse_pin = aligned & ~mode100;
    assign idle100_pin    = aligned & mode100;
endmodule : cln_partner

// file: testbench/cln_link_ctrl_tb.sv
// Self-checking bench for the link negotiation controller
`include "cln_defs.svh"
module cln_link_ctrl_tb;
    import cln_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DOWN = 50;
    logic ref_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] lp_abil_pin, abil;
    logic lp_page_pin, link_ok_pin, rx_energy_pin, link_pulse_pin;
    logic idle100_pin, mdix_sel, an_active, phy_speed100, phy_full;
    logic st_link, st_speed100, st_full, st_mdix;
    logic present, cable_cross, mode100, rd_ph;
    cln_state_t fsm_state;
    logic [31:0] exp_q[$];
    int miscompares, n_tests, seed;

    cln_link_ctrl #(.DOWN_CYCLES(DOWN), .SLOT_CYCLES(8)) u_dut (
        .ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .lp_abil_pin,
        .lp_page_pin, .link_ok_pin, .rx_energy_pin, .link_pulse_pin,
        .idle100_pin, .mdix_sel, .an_active, .phy_speed100, .phy_full,
        .st_link, .st_speed100, .st_full, .st_mdix, .fsm_state);
    cln_partner u_far (
        .ref_clk, .resetn, .mdix_sel, .present, .cable_cross, .mode100,
        .abil, .lp_abil_pin, .lp_page_pin, .link_ok_pin, .rx_energy_pin,
        .link_pulse_pin, .idle100_pin);

    assign hready = hreadyout;
    always #20 ref_clk = ~ref_clk;

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= ~w;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd_ph <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wait_st(input cln_state_t s);
        while (fsm_state !== s) @(posedge ref_clk);
    endtask : wait_st

    function automatic logic [31:0] stv(input logic l, s, f, m,
                                        input cln_state_t q);
        logic an;
        an = (q == S_AN_WAIT) || (q == S_AN_UP) || (q == S_TEMP_AN);
        return {22'h0, an, q, m, f, s, l};
    endfunction : stv

    // Result watcher: oldest expectation meets each read data phase
    always @(posedge ref_clk) begin
        if (rd_ph && hready === 1'b1) begin
            check("hrdata", hrdata, exp_q.pop_front());
            check("hresp", 32'(hresp), 32'h0000_0000);
        end
    end

    task automatic link_up(input logic [3:0] ctl, adv, pab,
                           input logic cab);
        logic [3:0] sh;
        logic spd, full, mx;
        sh = adv & pab;
        spd = sh[3] | sh[2];
        full = sh[3] | (~sh[2] & sh[1]);
        mx = ctl[3] & ~cab;
        present <= 1'b0;
        wait_st(S_AN_WAIT);
        bus(1'b1, `CLN_OFF_CTRL, {28'h0, ctl});
        bus(1'b1, `CLN_OFF_ADV, {28'h0, adv});
        rd(`CLN_OFF_ADV, {28'h0, adv});
        abil <= pab;
        cable_cross <= cab;
        present <= 1'b1;
        wait_st(S_AN_UP);
        check("phy_speed100", 32'(phy_speed100), 32'(spd));
        check("phy_full", 32'(phy_full), 32'(full));
        check("mdix_sel", 32'(mdix_sel), 32'(mx));
        rd(`CLN_OFF_STAT, stv(1'b1, spd, full, mx, S_AN_UP));
        repeat (20) @(posedge ref_clk);
        rd(`CLN_OFF_STAT, stv(1'b1, spd, full, mx, S_AN_UP));
    endtask : link_up

    task automatic forced(input logic [3:0] ctl, input logic m100);
        int n;
        present <= 1'b0;
        mode100 <= m100;
        bus(1'b1, `CLN_OFF_CTRL, {28'h0, ctl});
        wait_st(S_FORCED);
        n = 0;
        while (fsm_state !== S_TEMP_AN) begin
            n++;
            @(posedge ref_clk);
        end
        check("down_wait", 32'(n >= DOWN - 2 && n <= DOWN + 6),
              32'h1);
        check("an_active", 32'(an_active), 32'h0000_0001);
        cable_cross <= 1'($random(seed));
        present <= 1'b1;
        wait_st(S_FORCED_UP);
        check("phy_speed100", 32'(phy_speed100), 32'(ctl[1]));
        check("phy_full", 32'(phy_full), 32'(ctl[2]));
        rd(`CLN_OFF_STAT,
           stv(1'b1, ctl[1], ctl[2], ~cable_cross, S_FORCED_UP));
    endtask : forced

    initial begin
        logic [3:0] adv, pab;
        seed = 16;
        ref_clk = 1'b0;
        resetn = 1'b0;
        {hsel, hwrite, rd_ph, present, cable_cross, mode100} = 6'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        abil = 4'hF;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("mdix_sel", 32'(mdix_sel), 32'h0000_0000);
        rd(`CLN_OFF_CTRL, 32'h0000_0009);
        rd(`CLN_OFF_ADV, 32'h0000_000F);
        rd(8'h0C, 32'h0000_0000);
        bus(1'b1, `CLN_OFF_STAT, 32'hFFFF_FFFF);
        rd(`CLN_OFF_STAT, stv(1'b0, 1'b0, 1'b0, 1'b0, S_AN_WAIT));
        // First four pass one shared mode each, then random pairs
        for (int i = 0; i < 10; i++) begin
            adv = (i < 4) ? 4'hF : 4'($random(seed));
            pab = (i < 4) ? 4'(1 << i) : 4'($random(seed));
            if (adv == 4'h0) adv = 4'h1;
            if ((adv & pab) == 4'h0) pab = adv;
            link_up(4'h9, adv, pab, 1'($random(seed)));
        end
        link_up(4'h1, 4'hF, 4'hF, 1'b1);
        forced(4'hE, 1'b1);
        forced(4'h8, 1'b0);
        // Crossover off: the long-down fallback must never start
        // Link dropped first, so the swap is not cut under a live link
        present <= 1'b0;
        wait_st(S_FORCED);
        bus(1'b1, `CLN_OFF_CTRL, 32'h0000_0002);
        repeat (3 * DOWN) @(posedge ref_clk);
        check("fsm_state", 32'(fsm_state), 32'(S_FORCED));
        check("mdix_sel", 32'(mdix_sel), 32'h0000_0000);
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end
endmodule : cln_link_ctrl_tb
